// ### src/ssfe_exec.sv
// Execution unit for stores, stack, I/O bit, shift and flag operations.
// How it works
// - post-increment store writes, then pointer plus one.
// - pre-decrement store lowers pointer, then writes.
// - displaced store writes pointer plus displacement.
// - direct store writes at the given address.
// - push puts source register on stack.
// - pop loads destination register from stack.
// - I/O bit set or clear, two cycles.
// - left shift, zero into bit 0.
// - right shift, zero into bit 7.
// - rotate left through carry, flags updated.
// - rotate right through carry, flags updated.
// - arithmetic right shift keeps the sign bit.
// - nibble swap, no flag changes, one cycle.
// - selected register bit copied into transfer flag.
// - transfer flag copied into selected register bit.
// - overflow flag set or clear alone.
// - half-carry flag set or clear alone.
// - signed test flag set or clear alone.
`timescale 1ns/1ps
`default_nettype none
module ssfe_exec
  import ssfe_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              op_valid,
  input  wire ssfe_op_t          op_code,
  input  wire logic [RIDX_W-1:0] op_reg,
  input  wire logic [2:0]        op_bit,
  input  wire logic              op_ptr_z,
  input  wire logic [DISP_W-1:0] op_disp,
  input  wire logic [ADDR_W-1:0] op_addr,
  input  wire logic [IO_W-1:0]   op_io,
  output logic                   op_ready,
  output logic      [ADDR_W-1:0] dmem_addr,
  output logic      [DATA_W-1:0] dmem_wdata,
  output logic                   dmem_we,
  output logic                   dmem_re,
  input  wire logic [DATA_W-1:0] dmem_rdata,
  output logic      [IO_W-1:0]   io_addr,
  output logic      [2:0]        io_bit,
  output logic                   io_bit_value,
  output logic                   io_bit_we,
  output logic      [DATA_W-1:0] status_out,
  input  wire logic [RBUS_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_we,
  input  wire logic              reg_re,
  output logic      [DATA_W-1:0] reg_rdata
);

  // Two states suffice, since no operation here takes more than two cycles.
  typedef enum logic {S_IDLE, S_FINISH} ssfe_state_t;

  ssfe_state_t       state_r;
  logic              accept;
  logic              multi_cycle;
  logic              shift_op;
  logic              pop_pending_r;
  logic [RIDX_W-1:0] pop_idx_r;
  logic [ADDR_W-1:0] sp_r;
  logic [DATA_W-1:0] status_r;
  logic [DATA_W-1:0] status_nxt;
  logic [ADDR_W-1:0] ptr_y;
  logic [ADDR_W-1:0] ptr_z;
  logic [ADDR_W-1:0] ptr_cur;
  logic [ADDR_W-1:0] eff_addr;
  logic [DATA_W-1:0] src_data;
  logic [DATA_W-1:0] bus_gpr_data;
  logic [DATA_W-1:0] shift_result;
  logic              shift_c;
  logic              shift_z;
  logic              shift_n;
  logic              shift_v;
  logic              gpr_we;
  logic [RIDX_W-1:0] gpr_idx;
  logic [DATA_W-1:0] gpr_data;
  logic              ptr_we;
  logic [ADDR_W-1:0] ptr_data;
  logic              bus_gpr_we;
  logic [DATA_W-1:0] reg_rdata_r;

  // Ready is combinational, so a one-cycle operation may follow at the next edge.
  assign op_ready   = (state_r == S_IDLE);
  assign accept     = op_valid && op_ready;
  assign status_out = status_r;
  assign reg_rdata  = reg_rdata_r;
  assign ptr_cur    = op_ptr_z ? ptr_z : ptr_y;
  assign bus_gpr_we = reg_we && (reg_addr <= RBUS_GPR_LAST);

  // Memory, stack and I/O bit operations hold the unit for a second cycle.
  always_comb begin
    case (op_code)
      OP_STORE_INDIRECT,
      OP_STORE_POST_INC,
      OP_STORE_PRE_DEC,
      OP_STORE_DISPLACED,
      OP_STORE_DIRECT,
      OP_STACK_PUSH,
      OP_STACK_POP,
      OP_IO_BIT_SET,
      OP_IO_BIT_CLEAR: multi_cycle = 1'b1;
      default:         multi_cycle = 1'b0;
    endcase
  end

  // Shifts and rotates are the only operations that rewrite Z, C, N and V together.
  always_comb begin
    case (op_code)
      OP_LOGIC_SHIFT_LEFT,
      OP_LOGIC_SHIFT_RIGHT,
      OP_ROTATE_LEFT_CARRY,
      OP_ROTATE_RIGHT_CARRY,
      OP_ARITH_SHIFT_RIGHT: shift_op = 1'b1;
      default:              shift_op = 1'b0;
    endcase
  end

  // The second state only holds off new requests; all work starts at the accept edge.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= S_IDLE;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (accept && multi_cycle) begin
            state_r <= S_FINISH;
          end
        end
        S_FINISH: begin
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // Effective data address of the memory operations.
  always_comb begin
    case (op_code)
      OP_STORE_PRE_DEC:   eff_addr = ptr_cur - 16'h0001;
      OP_STORE_DISPLACED: eff_addr = ptr_cur + {10'h000, op_disp};
      OP_STORE_DIRECT:    eff_addr = op_addr;
      OP_STACK_PUSH:      eff_addr = sp_r;
      OP_STACK_POP:       eff_addr = sp_r + 16'h0001;
      default:            eff_addr = ptr_cur;
    endcase
  end

  // Pointer write-back; the displaced form leaves the pointer alone.
  always_comb begin
    ptr_we   = 1'b0;
    ptr_data = ptr_cur;
    if (accept && (op_code == OP_STORE_POST_INC)) begin
      ptr_we   = 1'b1;
      ptr_data = ptr_cur + 16'h0001;
    end else if (accept && (op_code == OP_STORE_PRE_DEC)) begin
      ptr_we   = 1'b1;
      ptr_data = ptr_cur - 16'h0001;
    end
  end

  // The data memory strobe stands in the second cycle of the operation.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dmem_addr  <= 16'h0000;
      dmem_wdata <= 8'h00;
      dmem_we    <= 1'b0;
      dmem_re    <= 1'b0;
    end else begin
      dmem_we <= 1'b0;
      dmem_re <= 1'b0;
      if (accept && multi_cycle && (op_code != OP_IO_BIT_SET)
          && (op_code != OP_IO_BIT_CLEAR)) begin
        dmem_addr  <= eff_addr;
        dmem_wdata <= src_data;
        dmem_we    <= (op_code != OP_STACK_POP);
        dmem_re    <= (op_code == OP_STACK_POP);
      end
    end
  end

  // Stack pointer: push writes then decrements, pop increments then reads.
  // Software writes to the stack pointer are lost in an accept cycle of push or pop.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sp_r <= SP_RESET;
    end else if (accept && (op_code == OP_STACK_PUSH)) begin
      sp_r <= sp_r - 16'h0001;
    end else if (accept && (op_code == OP_STACK_POP)) begin
      sp_r <= sp_r + 16'h0001;
    end else if (reg_we && (reg_addr == RBUS_SP_LO)) begin
      sp_r[7:0] <= reg_wdata;
    end else if (reg_we && (reg_addr == RBUS_SP_HI)) begin
      sp_r[15:8] <= reg_wdata;
    end
  end

  // Pop completes when the memory answers in its read cycle.
  // Memory must answer within the read cycle, as its data are not registered here.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pop_pending_r <= 1'b0;
      pop_idx_r     <= 5'h00;
    end else begin
      pop_pending_r <= accept && (op_code == OP_STACK_POP);
      if (accept) begin
        pop_idx_r <= op_reg;
      end
    end
  end

  // The I/O side performs the bit write itself, so no read is needed here.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      io_addr      <= 5'h00;
      io_bit       <= 3'h0;
      io_bit_value <= 1'b0;
      io_bit_we    <= 1'b0;
    end else begin
      io_bit_we <= 1'b0;
      if (accept && ((op_code == OP_IO_BIT_SET) || (op_code == OP_IO_BIT_CLEAR))) begin
        io_addr      <= op_io;
        io_bit       <= op_bit;
        io_bit_value <= (op_code == OP_IO_BIT_SET);
        io_bit_we    <= 1'b1;
      end
    end
  end

  // General register write from shift results or from a finishing pop.
  always_comb begin
    gpr_we   = 1'b0;
    gpr_idx  = op_reg;
    gpr_data = shift_result;
    if (pop_pending_r) begin
      gpr_we   = 1'b1;
      gpr_idx  = pop_idx_r;
      gpr_data = dmem_rdata;
    end else if (accept && (shift_op || (op_code == OP_NIBBLE_SWAP)
                 || (op_code == OP_TRANSFER_FLAG_TO_BIT))) begin
      gpr_we = 1'b1;
    end
  end

  // Status register; only the flags that an operation names are changed.
  always_comb begin
    status_nxt = status_r;
    if (accept) begin
      case (op_code)
        OP_LOGIC_SHIFT_LEFT,
        OP_LOGIC_SHIFT_RIGHT,
        OP_ROTATE_LEFT_CARRY,
        OP_ROTATE_RIGHT_CARRY,
        OP_ARITH_SHIFT_RIGHT: begin
          status_nxt[FLAG_C] = shift_c;
          status_nxt[FLAG_Z] = shift_z;
          status_nxt[FLAG_N] = shift_n;
          status_nxt[FLAG_V] = shift_v;
        end
        OP_BIT_TO_TRANSFER_FLAG: status_nxt[FLAG_T] = src_data[op_bit];
        OP_FLAG_SET:             status_nxt[op_bit] = 1'b1;
        OP_FLAG_CLEAR:           status_nxt[op_bit] = 1'b0;
        OP_OVERFLOW_FLAG_SET:    status_nxt[FLAG_V] = 1'b1;
        OP_OVERFLOW_FLAG_CLEAR:  status_nxt[FLAG_V] = 1'b0;
        OP_HALF_CARRY_SET:       status_nxt[FLAG_H] = 1'b1;
        OP_HALF_CARRY_CLEAR:     status_nxt[FLAG_H] = 1'b0;
        OP_SIGNED_FLAG_SET:      status_nxt[FLAG_S] = 1'b1;
        OP_SIGNED_FLAG_CLEAR:    status_nxt[FLAG_S] = 1'b0;
        default:                 status_nxt = status_r;
      endcase
    end
  end

  // A flag-changing operation in the same cycle overrides a software write.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      status_r <= STATUS_RESET;
    end else if (status_nxt != status_r) begin
      status_r <= status_nxt;
    end else if (reg_we && (reg_addr == RBUS_STATUS) && !(accept && !multi_cycle)) begin
      status_r <= reg_wdata;
    end
  end

  // Register port read; unmapped addresses read as zero.
  // Data stand for one cycle only, so a late reader sees zero.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_r <= 8'h00;
    end else if (!reg_re) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_addr <= RBUS_GPR_LAST) begin
      reg_rdata_r <= bus_gpr_data;
    end else if (reg_addr == RBUS_STATUS) begin
      reg_rdata_r <= status_r;
    end else if (reg_addr == RBUS_SP_LO) begin
      reg_rdata_r <= sp_r[7:0];
    end else if (reg_addr == RBUS_SP_HI) begin
      reg_rdata_r <= sp_r[15:8];
    end else begin
      reg_rdata_r <= 8'h00;
    end
  end

  // The shift unit has no state; its result is written back at the accept edge.
  ssfe_shift_unit ssfe_shift_unit_inst (
    .op       (op_code),
    .operand  (src_data),
    .carry_in (status_r[FLAG_C]),
    .t_flag   (status_r[FLAG_T]),
    .bit_sel  (op_bit),
    .result   (shift_result),
    .flag_c   (shift_c),
    .flag_z   (shift_z),
    .flag_n   (shift_n),
    .flag_v   (shift_v)
  );

  // Port a serves the operation and port b the software register port.
  ssfe_regfile ssfe_regfile_inst (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .rd_idx_a  (op_reg),
    .rd_data_a (src_data),
    .rd_idx_b  (reg_addr[RIDX_W-1:0]),
    .rd_data_b (bus_gpr_data),
    .ptr_y     (ptr_y),
    .ptr_z     (ptr_z),
    .we_a      (gpr_we),
    .wr_idx_a  (gpr_idx),
    .wr_data_a (gpr_data),
    .we_b      (bus_gpr_we),
    .wr_idx_b  (reg_addr[RIDX_W-1:0]),
    .wr_data_b (reg_wdata),
    .ptr_we    (ptr_we),
    .ptr_sel_z (op_ptr_z),
    .ptr_data  (ptr_data)
  );

endmodule
`default_nettype wire

// ### src/ssfe_pkg.sv
// Shared constants and types of the store, shift and flag execution block.
package ssfe_pkg;

  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ADDR_W   = 16;
  localparam int unsigned RIDX_W   = 5;
  localparam int unsigned IO_W     = 5;
  localparam int unsigned DISP_W   = 6;
  localparam int unsigned RBUS_W   = 6;
  localparam int unsigned NUM_REGS = 32;

  // Register port map.
  localparam logic [RBUS_W-1:0] RBUS_GPR_LAST = 6'h1F;
  localparam logic [RBUS_W-1:0] RBUS_STATUS   = 6'h20;
  localparam logic [RBUS_W-1:0] RBUS_SP_LO    = 6'h21;
  localparam logic [RBUS_W-1:0] RBUS_SP_HI    = 6'h22;

  // Values after reset.
  localparam logic [DATA_W-1:0] GPR_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] SP_RESET     = 16'h0000;

  // Pointer pairs: low byte index, high byte is the next register.
  localparam logic [RIDX_W-1:0] PTR_Y_LO = 5'h1C;
  localparam logic [RIDX_W-1:0] PTR_Z_LO = 5'h1E;

  // Bit positions in the status register.
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_STORE_INDIRECT,
    OP_STORE_POST_INC,
    OP_STORE_PRE_DEC,
    OP_STORE_DISPLACED,
    OP_STORE_DIRECT,
    OP_STACK_PUSH,
    OP_STACK_POP,
    OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR,
    OP_LOGIC_SHIFT_LEFT,
    OP_LOGIC_SHIFT_RIGHT,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY,
    OP_ARITH_SHIFT_RIGHT,
    OP_NIBBLE_SWAP,
    OP_BIT_TO_TRANSFER_FLAG,
    OP_TRANSFER_FLAG_TO_BIT,
    OP_FLAG_SET,
    OP_FLAG_CLEAR,
    OP_OVERFLOW_FLAG_SET,
    OP_OVERFLOW_FLAG_CLEAR,
    OP_HALF_CARRY_SET,
    OP_HALF_CARRY_CLEAR,
    OP_SIGNED_FLAG_SET,
    OP_SIGNED_FLAG_CLEAR
  } ssfe_op_t;

endpackage

// ### src/ssfe_shift_unit.sv
// Combinational shift, rotate, nibble swap and bit load unit.
`timescale 1ns/1ps
`default_nettype none
module ssfe_shift_unit
  import ssfe_pkg::*;
(
  input  wire ssfe_op_t          op,
  input  wire logic [DATA_W-1:0] operand,
  input  wire logic              carry_in,
  input  wire logic              t_flag,
  input  wire logic [2:0]        bit_sel,
  output logic      [DATA_W-1:0] result,
  output logic                   flag_c,
  output logic                   flag_z,
  output logic                   flag_n,
  output logic                   flag_v
);

  always_comb begin
    result = operand;
    flag_c = carry_in;
    case (op)
      OP_LOGIC_SHIFT_LEFT: begin
        result = {operand[6:0], 1'b0};
        flag_c = operand[7];
      end
      OP_LOGIC_SHIFT_RIGHT: begin
        result = {1'b0, operand[7:1]};
        flag_c = operand[0];
      end
      OP_ROTATE_LEFT_CARRY: begin
        result = {operand[6:0], carry_in};
        flag_c = operand[7];
      end
      OP_ROTATE_RIGHT_CARRY: begin
        result = {carry_in, operand[7:1]};
        flag_c = operand[0];
      end
      OP_ARITH_SHIFT_RIGHT: begin
        result = {operand[7], operand[7:1]};
        flag_c = operand[0];
      end
      OP_NIBBLE_SWAP: begin
        result = {operand[3:0], operand[7:4]};
      end
      OP_TRANSFER_FLAG_TO_BIT: begin
        result[bit_sel] = t_flag;
      end
      default: begin
        result = operand;
      end
    endcase
    flag_z = (result == 8'h00);
    flag_n = result[7];
    // Overflow after a shift is N xor C, which is the sign change only for left shifts.
    flag_v = result[7] ^ flag_c;
  end

endmodule
`default_nettype wire

// ### src/ssfe_regfile.sv
// Thirty-two general registers in flip-flops with pointer access.
`timescale 1ns/1ps
`default_nettype none
module ssfe_regfile
  import ssfe_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic [RIDX_W-1:0] rd_idx_a,
  output logic      [DATA_W-1:0] rd_data_a,
  input  wire logic [RIDX_W-1:0] rd_idx_b,
  output logic      [DATA_W-1:0] rd_data_b,
  output logic      [ADDR_W-1:0] ptr_y,
  output logic      [ADDR_W-1:0] ptr_z,
  input  wire logic              we_a,
  input  wire logic [RIDX_W-1:0] wr_idx_a,
  input  wire logic [DATA_W-1:0] wr_data_a,
  input  wire logic              we_b,
  input  wire logic [RIDX_W-1:0] wr_idx_b,
  input  wire logic [DATA_W-1:0] wr_data_b,
  input  wire logic              ptr_we,
  input  wire logic              ptr_sel_z,
  input  wire logic [ADDR_W-1:0] ptr_data
);

  logic [DATA_W-1:0] regs_r [NUM_REGS];
  logic [RIDX_W-1:0] ptr_lo;

  assign ptr_lo    = ptr_sel_z ? PTR_Z_LO : PTR_Y_LO;
  assign rd_data_a = regs_r[rd_idx_a];
  assign rd_data_b = regs_r[rd_idx_b];
  assign ptr_y     = {regs_r[PTR_Y_LO + 5'h01], regs_r[PTR_Y_LO]};
  assign ptr_z     = {regs_r[PTR_Z_LO + 5'h01], regs_r[PTR_Z_LO]};

  // The execution path wins over the software port on the same register.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= GPR_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        if (ptr_we && (RIDX_W'(i) == ptr_lo)) begin
          regs_r[i] <= ptr_data[7:0];
        end else if (ptr_we && (RIDX_W'(i) == ptr_lo + 5'h01)) begin
          regs_r[i] <= ptr_data[15:8];
        end else if (we_a && (RIDX_W'(i) == wr_idx_a)) begin
          regs_r[i] <= wr_data_a;
        end else if (we_b && (RIDX_W'(i) == wr_idx_b)) begin
          regs_r[i] <= wr_data_b;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### testbench/ssfe_exec_sva.sv
// Checker of the store, stack, bit, shift and flag execution block.
`timescale 1ns/1ps
`default_nettype none
module ssfe_exec_sva
  import ssfe_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              resetn,
  input wire logic              op_valid,
  input wire ssfe_op_t          op_code,
  input wire logic [2:0]        op_bit,
  input wire logic [ADDR_W-1:0] op_addr,
  input wire logic [IO_W-1:0]   op_io,
  input wire logic              op_ready,
  input wire logic [ADDR_W-1:0] dmem_addr,
  input wire logic              dmem_we,
  input wire logic              dmem_re,
  input wire logic [IO_W-1:0]   io_addr,
  input wire logic [2:0]        io_bit,
  input wire logic              io_bit_value,
  input wire logic              io_bit_we,
  input wire logic [DATA_W-1:0] status_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic take;
  logic st_op;
  logic sh_op;
  logic set_op;
  assign take = op_valid && op_ready;
  assign st_op = op_code inside {OP_STORE_INDIRECT, OP_STORE_POST_INC, OP_STORE_PRE_DEC,
                                 OP_STORE_DISPLACED, OP_STORE_DIRECT, OP_STACK_PUSH};
  assign sh_op = op_code inside {OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT, OP_ROTATE_LEFT_CARRY,
                                 OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT};
  assign set_op = op_code inside {OP_OVERFLOW_FLAG_SET, OP_HALF_CARRY_SET, OP_SIGNED_FLAG_SET,
                                  OP_IO_BIT_SET};
  // A memory slot keeps the port busy for exactly one cycle.
  sequence s_write_slot;
    dmem_we && !op_ready ##1 !dmem_we && op_ready;
  endsequence
  sequence s_read_slot;
    dmem_re && !dmem_we && !op_ready ##1 !dmem_re && op_ready;
  endsequence
  AST_STORE_SLOT: assert property (take && st_op
    |=> s_write_slot) else $error("store slot wrong");
  AST_STORE_FLAGS: assert property (take && st_op
    |=> $stable(status_out) [*2]) else $error("store changed flags");
  AST_DIRECT_ADDR: assert property (take && op_code == OP_STORE_DIRECT
    |=> dmem_addr == $past(op_addr)) else $error("direct address wrong");
  AST_POP_SLOT: assert property (take && op_code == OP_STACK_POP |=> s_read_slot)
    else $error("pop slot wrong");
  AST_IO_BIT: assert property (take &&
    op_code inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR} |=> io_bit_we && !op_ready
    && io_addr == $past(op_io) && io_bit == $past(op_bit) && io_bit_value == $past(set_op))
    else $error("io bit write wrong");
  AST_SHIFT_V: assert property (take && sh_op
    |=> op_ready && status_out[FLAG_V] == (status_out[FLAG_N] ^ status_out[FLAG_C]))
    else $error("shift V wrong");
  AST_NO_FLAGS: assert property (take &&
    op_code inside {OP_NIBBLE_SWAP, OP_TRANSFER_FLAG_TO_BIT} |=> $stable(status_out) && op_ready)
    else $error("flags changed");
  AST_T_ONLY: assert property (take && op_code == OP_BIT_TO_TRANSFER_FLAG |=>
    ((status_out ^ $past(status_out)) & 8'hBF) == 8'h00) else $error("bit store touched flags");
  AST_V_FLAG: assert property (take &&
    op_code inside {OP_OVERFLOW_FLAG_SET, OP_OVERFLOW_FLAG_CLEAR}
    |=> status_out[FLAG_V] == $past(set_op)
    && ((status_out ^ $past(status_out)) & 8'hF7) == 8'h00) else $error("overflow flag op wrong");
  AST_H_FLAG: assert property (take &&
    op_code inside {OP_HALF_CARRY_SET, OP_HALF_CARRY_CLEAR}
    |=> status_out[FLAG_H] == $past(set_op)
    && ((status_out ^ $past(status_out)) & 8'hDF) == 8'h00) else $error("half carry op wrong");
  AST_S_FLAG: assert property (take &&
    op_code inside {OP_SIGNED_FLAG_SET, OP_SIGNED_FLAG_CLEAR}
    |=> status_out[FLAG_S] == $past(set_op)
    && ((status_out ^ $past(status_out)) & 8'hEF) == 8'h00) else $error("signed flag op wrong");
endmodule
bind ssfe_exec ssfe_exec_sva ssfe_exec_sva_inst (
  .ref_clk(ref_clk), .resetn(resetn), .op_valid(op_valid), .op_code(op_code), .op_bit(op_bit),
  .op_addr(op_addr), .op_io(op_io), .op_ready(op_ready), .dmem_addr(dmem_addr),
  .dmem_we(dmem_we), .dmem_re(dmem_re), .io_addr(io_addr), .io_bit(io_bit),
  .io_bit_value(io_bit_value), .io_bit_we(io_bit_we), .status_out(status_out)
);
`default_nettype wire

// ### testbench/store_shift_flag_exec_bench.sv
// Self-checking testbench of the store, stack, bit, shift and flag execution block.
`timescale 1ns/1ps
`default_nettype none
module store_shift_flag_exec_bench
  import ssfe_pkg::*;
;
  logic ref_clk, resetn, op_valid, op_ptr_z, op_ready, dmem_we, dmem_re;
  logic io_bit_value, io_bit_we, reg_we, reg_re;
  ssfe_op_t op_code;
  logic [4:0] op_reg, op_io, io_addr;
  logic [2:0] op_bit, io_bit;
  logic [5:0] op_disp, reg_addr;
  logic [15:0] op_addr, dmem_addr, e;
  logic [7:0] dmem_wdata, dmem_rdata, status_out, reg_wdata, reg_rdata, p;
  logic cin;
  int fails = 0;
  int check_count = 0;
  ssfe_op_t sops[5] = '{OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT, OP_ROTATE_LEFT_CARRY,
                        OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT};
  ssfe_op_t fops[6] = '{OP_OVERFLOW_FLAG_SET, OP_OVERFLOW_FLAG_CLEAR, OP_HALF_CARRY_SET,
                        OP_HALF_CARRY_CLEAR, OP_SIGNED_FLAG_SET, OP_SIGNED_FLAG_CLEAR};
  int fbit[6] = '{3, 3, 5, 5, 4, 4};
  logic [7:0] vals[2] = '{8'h81, 8'h80};

  ssfe_exec ssfe_exec_inst (
    .ref_clk(ref_clk), .resetn(resetn), .op_valid(op_valid), .op_code(op_code),
    .op_reg(op_reg), .op_bit(op_bit), .op_ptr_z(op_ptr_z), .op_disp(op_disp),
    .op_addr(op_addr), .op_io(op_io), .op_ready(op_ready), .dmem_addr(dmem_addr),
    .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .dmem_re(dmem_re), .dmem_rdata(dmem_rdata),
    .io_addr(io_addr), .io_bit(io_bit), .io_bit_value(io_bit_value), .io_bit_we(io_bit_we),
    .status_out(status_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_we <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rc(input logic [5:0] a, input logic [7:0] x);
    @(posedge ref_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_re <= 1'b0;
    #1 chk({8'h00, reg_rdata}, {8'h00, x});
  endtask

  task automatic op(input ssfe_op_t c, input logic [4:0] r = 5'h00, input logic [2:0] b = 3'h0,
                    input logic z = 1'b0, input logic [5:0] q = 6'h00,
                    input logic [15:0] k = 16'h0000, input logic [4:0] io = 5'h00);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_reg <= r;
    op_bit <= b;
    op_ptr_z <= z;
    op_disp <= q;
    op_addr <= k;
    op_io <= io;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    #1;
  endtask

  task automatic mw(input logic [15:0] a, input logic [7:0] d);
    chk(dmem_addr, a);
    chk({6'h00, dmem_we, op_ready, dmem_wdata}, {8'h02, d});
  endtask

  function automatic logic [15:0] shx(input ssfe_op_t c, input logic [7:0] v, input logic ci);
    logic [7:0] r;
    logic co;
    co = v[0];
    case (c)
      OP_LOGIC_SHIFT_LEFT: begin
        r = {v[6:0], 1'b0};
        co = v[7];
      end
      OP_ROTATE_LEFT_CARRY: begin
        r = {v[6:0], ci};
        co = v[7];
      end
      OP_LOGIC_SHIFT_RIGHT: r = {1'b0, v[7:1]};
      OP_ROTATE_RIGHT_CARRY: r = {ci, v[7:1]};
      default: r = {v[7], v[7:1]};
    endcase
    return {r, 4'hF, r[7] ^ co, r[7], r == 8'h00, co};
  endfunction

  // The span is generous against the few hundred cycles that the tests need.
  initial begin
    #200us;
    fails++;
    final_report();
  end

  initial begin
    {op_valid, op_ptr_z, reg_we, reg_re} = 4'h0;
    op_code = OP_NOP;
    {op_reg, op_bit, op_disp, op_addr, op_io, reg_addr, reg_wdata, dmem_rdata} = '0;
    resetn = 1'b0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    chk({15'h0000, op_ready}, 16'h0001);
    rc(RBUS_STATUS, STATUS_RESET);
    wr(6'h1C, 8'h10);
    wr(6'h1D, 8'h01);
    wr(6'h1E, 8'h00);
    wr(6'h1F, 8'h02);
    wr(6'h05, 8'hA5);
    wr(RBUS_STATUS, 8'h5A);
    wr(6'h30, 8'hFF);
    op(OP_STORE_POST_INC, 5'h05);
    mw(16'h0110, 8'hA5);
    rc(6'h1C, 8'h11);
    op(OP_STORE_PRE_DEC, 5'h05, 3'h0, 1'b1);
    mw(16'h01FF, 8'hA5);
    rc(6'h1E, 8'hFF);
    rc(6'h1F, 8'h01);
    op(OP_STORE_INDIRECT, 5'h05, 3'h0, 1'b1);
    mw(16'h01FF, 8'hA5);
    rc(6'h1E, 8'hFF);
    op(OP_STORE_DISPLACED, 5'h05, 3'h0, 1'b0, 6'h3F);
    mw(16'h0150, 8'hA5);
    rc(6'h1C, 8'h11);
    op(OP_STORE_DIRECT, 5'h05, 3'h0, 1'b0, 6'h00, 16'hBEEF);
    mw(16'hBEEF, 8'hA5);
    rc(RBUS_STATUS, 8'h5A);
    $display("Test stores done");
    wr(RBUS_SP_LO, 8'h80);
    op(OP_STACK_PUSH, 5'h05);
    mw(16'h0080, 8'hA5);
    rc(RBUS_SP_LO, 8'h7F);
    dmem_rdata <= 8'h3C;
    op(OP_STACK_POP, 5'h07);
    chk({dmem_addr[14:0], dmem_re}, 16'h0101);
    rc(6'h07, 8'h3C);
    rc(RBUS_SP_LO, 8'h80);
    rc(RBUS_STATUS, 8'h5A);
    $display("Test stack done");
    op(OP_IO_BIT_SET, 5'h00, 3'h7, 1'b0, 6'h00, 16'h0000, 5'h1F);
    chk({6'h00, io_bit_we, io_bit_value, io_bit, io_addr}, 16'h03FF);
    op(OP_IO_BIT_CLEAR, 5'h00, 3'h0, 1'b0, 6'h00, 16'h0000, 5'h00);
    chk({6'h00, io_bit_we, io_bit_value, io_bit, io_addr}, 16'h0200);
    $display("Test io bits done");
    foreach (sops[i]) begin
      for (int j = 0; j < 2; j++) begin
        cin = (j == 0);
        wr(6'h01, vals[j]);
        wr(RBUS_STATUS, {7'h78, cin});
        op(sops[i], 5'h01);
        e = shx(sops[i], vals[j], cin);
        rc(6'h01, e[15:8]);
        rc(RBUS_STATUS, e[7:0]);
      end
    end
    wr(6'h04, 8'h3C);
    wr(RBUS_STATUS, 8'h55);
    op(OP_NIBBLE_SWAP, 5'h04);
    rc(6'h04, 8'hC3);
    rc(RBUS_STATUS, 8'h55);
    $display("Test shifts done");
    wr(6'h02, 8'h04);
    op(OP_BIT_TO_TRANSFER_FLAG, 5'h02, 3'h3);
    rc(RBUS_STATUS, 8'h15);
    op(OP_BIT_TO_TRANSFER_FLAG, 5'h02, 3'h2);
    rc(RBUS_STATUS, 8'h55);
    op(OP_TRANSFER_FLAG_TO_BIT, 5'h03, 3'h5);
    rc(6'h03, 8'h20);
    for (int k = 0; k < 6; k++) begin
      p = 8'h01 << fbit[k];
      wr(RBUS_STATUS, k[0] ? 8'hFF : 8'h00);
      op(fops[k]);
      rc(RBUS_STATUS, k[0] ? ~p : p);
    end
    wr(RBUS_STATUS, 8'h00);
    op(OP_FLAG_SET, 5'h00, 3'h5);
    rc(RBUS_STATUS, 8'h20);
    op(OP_FLAG_CLEAR, 5'h00, 3'h5);
    rc(RBUS_STATUS, 8'h00);
    $display("Test flags done");
    final_report();
  end
endmodule
`default_nettype wire
